// File: logic/pspc_top.sv
/*
  Per-port power control for one PSE port of two power channels:
  inrush timing, policing, current-limit timeout, switch fault, disconnect.
  Assumes analog comparators on pins, power averages from same-clock
  measurement logic, and an AXI4-Lite master for the registers.
*/
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module pspc_top #(
  parameter int START_CYC = pspc_pkg::START_CYC,
  parameter int DIS_CYC = pspc_pkg::DIS_CYC,
  parameter int SWF_CYC = pspc_pkg::SWF_CYC,
  parameter int LIM50_CYC = pspc_pkg::LIM50_CYC,
  parameter int LIM15_CYC = pspc_pkg::LIM15_CYC,
  parameter int LIM10_CYC = pspc_pkg::LIM10_CYC,
  parameter int LIM6_CYC = pspc_pkg::LIM6_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog comparators, per channel except the single supplySurge
  input wire logic [1:0] overInrush,
  input wire logic [1:0] overCurrentLimit,
  input wire logic [1:0] belowHoldCurrent,
  input wire logic [1:0] outputGood,
  input wire logic [1:0] switchAbnormal,
  input wire logic [1:0] voltLowStage1,
  input wire logic [1:0] voltLowStage2,
  input wire logic supplySurge,
  // Power averages, 0.5 W units
  input wire logic [9:0] portPowerAvg,
  input wire logic [8:0] chPowerAvg0,
  input wire logic [8:0] chPowerAvg1,
  // Gate and analog settings
  output logic [1:0] gateEnable,
  output logic [1:0] inrushLimitHalf,
  output logic [3:0] currentLimitSel,
  output logic [3:0] foldbackStage,
  output logic [1:0] holdThresholdHigh,
  output logic gatePulldownWeak
);

  // ==========================================================================
  // Pin synchronisers
  localparam int NSYNC = 15;
  logic [NSYNC-1:0] syncA, syncB, syncC, pinReg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
    end else begin
      syncA <= {supplySurge, voltLowStage2, voltLowStage1, switchAbnormal, outputGood,
                belowHoldCurrent, overCurrentLimit, overInrush};
      syncB <= syncA;
      syncC <= syncB;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      pinReg <= '0;
    end else begin
      for (int i = 0; i < NSYNC; i++) begin
        if (syncB[i] == syncC[i]) begin
          pinReg[i] <= syncC[i];
        end
      end
    end
  end
  logic [1:0] sOverInr, sOverLim, sBelowHold, sOutGood, sSwAbn, sLow1, sLow2;
  logic sSurge;
  assign sOverInr = pinReg[1:0];
  assign sOverLim = pinReg[3:2];
  assign sBelowHold = pinReg[5:4];
  assign sOutGood = pinReg[7:6];
  assign sSwAbn = pinReg[9:8];
  assign sLow1 = pinReg[11:10];
  assign sLow2 = pinReg[13:12];
  assign sSurge = pinReg[14];

  // ==========================================================================
  // Registers
  logic [31:0] ctrlReg;
  logic [8:0] portThrReg, chThr0Reg, chThr1Reg;
  logic [3:0] tlimReg;
  logic [8:0] faultReg;
  logic cmdOnReg, cmdOffReg, cmdResetReg;
  pspc_pkg::pspc_ch_e chState [2];

  logic [1:0] chanEn, dcEn;
  logic [3:0] pdClass;
  logic [2:0] classEvents;
  logic shutdownMode, dualSig, pcut4p, ilim4p, autoMode, ss4p, swFault;
  assign chanEn = ctrlReg[pspc_pkg::CTRL_CHEN +: 2];
  assign dcEn = ctrlReg[pspc_pkg::CTRL_DCEN +: 2];
  assign pdClass = ctrlReg[pspc_pkg::CTRL_CLASS +: 4];
  assign classEvents = ctrlReg[pspc_pkg::CTRL_EVENTS +: 3];
  assign shutdownMode = ctrlReg[pspc_pkg::CTRL_SHUTDOWN];
  assign dualSig = ctrlReg[pspc_pkg::CTRL_DUAL];
  assign pcut4p = ctrlReg[pspc_pkg::CTRL_PCUT4P];
  assign ilim4p = ctrlReg[pspc_pkg::CTRL_ILIM4P];
  assign autoMode = ctrlReg[pspc_pkg::CTRL_AUTO];
  assign ss4p = (chanEn == 2'b11) && !dualSig;
  assign swFault = faultReg[pspc_pkg::FLT_SWITCH];

  // ==========================================================================
  // AXI4-Lite slave
  logic [7:0] awAddrReg, arAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  logic awFull, wFull, doWrite;
  assign doWrite = awFull && wFull && !s_axi_bvalid;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= pspc_pkg::ADDR_FAULT);
  endfunction : mapped

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
    end
  endfunction : merge

  logic wrCtrl, wrPortThr, wrChThr, wrTlim, wrFault;
  assign wrCtrl = doWrite && (awAddrReg == pspc_pkg::ADDR_CTRL);
  assign wrPortThr = doWrite && (awAddrReg == pspc_pkg::ADDR_PORT_THR);
  assign wrChThr = doWrite && (awAddrReg == pspc_pkg::ADDR_CH_THR);
  assign wrTlim = doWrite && (awAddrReg == pspc_pkg::ADDR_TLIM);
  assign wrFault = doWrite && (awAddrReg == pspc_pkg::ADDR_FAULT);

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awFull <= 1'b0;
      wFull <= 1'b0;
      awAddrReg <= '0;
      wDataReg <= '0;
      wStrbReg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pspc_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddrReg <= s_axi_awaddr;
        awFull <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
        wFull <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awAddrReg) ? pspc_pkg::AXI_OKAY : pspc_pkg::AXI_SLVERR;
        awFull <= 1'b0;
        wFull <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  logic [31:0] readMux;
  always_comb begin
    readMux = 32'h0000_0000;
    case (arAddrReg)
      pspc_pkg::ADDR_CTRL: readMux = {ctrlReg[31:3], 3'b000};
      pspc_pkg::ADDR_PORT_THR: readMux = {23'h000000, portThrReg};
      pspc_pkg::ADDR_CH_THR: readMux = {7'h00, chThr1Reg, 7'h00, chThr0Reg};
      pspc_pkg::ADDR_TLIM: readMux = {28'h0000000, tlimReg};
      pspc_pkg::ADDR_STATUS: readMux = {22'h000000, gateEnable, sSurge, 3'b000,
                                        chState[1], chState[0]};
      pspc_pkg::ADDR_FAULT: readMux = {23'h000000, faultReg};
      default: readMux = 32'h0000_0000;
    endcase
  end

  logic arPend;
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      arPend <= 1'b0;
      arAddrReg <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pspc_pkg::AXI_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        arAddrReg <= s_axi_araddr;
        arPend <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (arPend) begin
        arPend <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readMux;
        s_axi_rresp <= mapped(arAddrReg) ? pspc_pkg::AXI_OKAY : pspc_pkg::AXI_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Configuration and command pulses
  logic [31:0] ctrlMerged, chThrMerged, portMerged;
  assign ctrlMerged = merge(ctrlReg, wDataReg, wStrbReg);
  assign chThrMerged = merge({7'h00, chThr1Reg, 7'h00, chThr0Reg}, wDataReg, wStrbReg);
  assign portMerged = merge({23'h000000, portThrReg}, wDataReg, wStrbReg);
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrlReg <= pspc_pkg::CTRL_RESET_VAL;
      cmdOnReg <= 1'b0;
      cmdOffReg <= 1'b0;
      cmdResetReg <= 1'b0;
    end else begin
      cmdOnReg <= wrCtrl && ctrlMerged[pspc_pkg::CTRL_ON];
      cmdOffReg <= wrCtrl && ctrlMerged[pspc_pkg::CTRL_OFF];
      cmdResetReg <= wrCtrl && ctrlMerged[pspc_pkg::CTRL_RESET];
      if (wrCtrl) begin
        ctrlReg <= {ctrlMerged[31:3], 3'b000};
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      portThrReg <= pspc_pkg::THR_RESET_VAL;
      chThr0Reg <= pspc_pkg::THR_RESET_VAL;
      chThr1Reg <= pspc_pkg::THR_RESET_VAL;
    end else begin
      if (wrPortThr) begin
        portThrReg <= portMerged[8:0];
      end
      if (wrChThr) begin
        chThr0Reg <= chThrMerged[8:0];
        chThr1Reg <= chThrMerged[24:16];
      end
    end
  end

  // Timeout selector by PD type: 00 Type1, 10 Type2/3, 11 Type4
  logic [1:0] autoSel;
  assign autoSel = (pdClass >= 4'd7) ? 2'b11 : (pdClass >= 4'd4) ? 2'b10 : 2'b00;
  always_ff @(posedge mclk) begin
    if (rst) begin
      tlimReg <= pspc_pkg::TLIM_RESET_VAL;
    end else if (cmdOnReg && autoMode) begin
      tlimReg <= {autoSel, autoSel};
    end else if (wrTlim && wStrbReg[0]) begin
      tlimReg <= wDataReg[3:0];
    end
  end

  function automatic logic [pspc_pkg::CNT_W-1:0] limCycles(input logic [1:0] sel);
    case (sel)
      2'b00: limCycles = pspc_pkg::CNT_W'(LIM50_CYC);
      2'b01: limCycles = pspc_pkg::CNT_W'(LIM15_CYC);
      2'b10: limCycles = pspc_pkg::CNT_W'(LIM10_CYC);
      default: limCycles = pspc_pkg::CNT_W'(LIM6_CYC);
    endcase
  endfunction : limCycles

  function automatic logic [1:0] ilimFromThr(input logic [8:0] thr);
    if (thr <= pspc_pkg::THR_ILIM_LOW_MAX) ilimFromThr = 2'b00;
    else if (thr <= pspc_pkg::THR_ILIM_MID_MAX) ilimFromThr = 2'b01;
    else ilimFromThr = 2'b10;
  endfunction : ilimFromThr

  // ==========================================================================
  // Per-channel timers and events
  logic [8:0] chThr [2];
  logic [8:0] chAvg [2];
  assign chThr[0] = chThr0Reg;
  assign chThr[1] = chThr1Reg;
  assign chAvg[0] = chPowerAvg0;
  assign chAvg[1] = chPowerAvg1;

  logic [1:0] inInrush, isOn, startDone, startFail, pcutCh, ilimEv, disExp;
  logic [pspc_pkg::CNT_W-1:0] stCnt [2];
  logic [pspc_pkg::CNT_W-1:0] limCnt [2];
  logic [pspc_pkg::CNT_W-1:0] disCnt [2];
  logic portPcut;
  assign portPcut = (portPowerAvg > {1'b0, portThrReg}) && (isOn != 2'b00);

  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign inInrush[c] = (chState[c] == pspc_pkg::CH_INRUSH);
    assign isOn[c] = (chState[c] == pspc_pkg::CH_ON);
    assign startDone[c] = (stCnt[c] >= pspc_pkg::CNT_W'(START_CYC - 1));
    // Needs output up and current under the inrush limit
    assign startFail[c] = inInrush[c] && startDone[c]
                          && !(sOutGood[c] && !sOverInr[c]);
    assign pcutCh[c] = isOn[c] && (chAvg[c] > chThr[c]);
    assign ilimEv[c] = isOn[c] && (limCnt[c] >= limCycles(tlimReg[2*c +: 2]) - 1'b1);
    assign disExp[c] = isOn[c] && (disCnt[c] >= pspc_pkg::CNT_W'(DIS_CYC - 1));

    always_ff @(posedge mclk) begin
      if (rst || !inInrush[c]) begin
        stCnt[c] <= '0;
      end else if (!startDone[c]) begin
        stCnt[c] <= stCnt[c] + 1'b1;
      end
    end
    always_ff @(posedge mclk) begin
      if (rst || !isOn[c] || !sOverLim[c]) begin
        limCnt[c] <= '0;
      end else if (!ilimEv[c]) begin
        limCnt[c] <= limCnt[c] + 1'b1;
      end
    end
    always_ff @(posedge mclk) begin
      if (rst || !isOn[c] || !sBelowHold[c] || !dcEn[c]) begin
        disCnt[c] <= '0;
      end else if (!disExp[c]) begin
        disCnt[c] <= disCnt[c] + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Kill decisions; no AC disconnect path exists
  logic [1:0] startKill, pcutSet, ilimSet, discKill, onKill, startSet;
  logic hostKill;
  assign hostKill = cmdOffReg || cmdResetReg || shutdownMode || swFault;
  for (genvar c = 0; c < 2; c++) begin : g_kill
    localparam int O = 1 - c;
    assign startKill[c] = startFail[c] || (ss4p && startFail[O]);
    assign startSet[c] = inInrush[c] && startKill[c];
    assign pcutSet[c] = isOn[c] && (pcutCh[c] || portPcut
                        || (ss4p && pcut4p && pcutCh[O]));
    assign ilimSet[c] = isOn[c] && (ilimEv[c] || (ss4p && ilim4p && ilimEv[O]));
    assign discKill[c] = isOn[c] && ((dualSig || chanEn != 2'b11) ? disExp[c]
                         : (disExp[0] && disExp[1]));
    assign onKill[c] = pcutSet[c] || ilimSet[c] || discKill[c];
  end

  // ==========================================================================
  // Channel state machines
  for (genvar c = 0; c < 2; c++) begin : g_fsm
    always_ff @(posedge mclk) begin
      if (rst) begin
        chState[c] <= pspc_pkg::CH_OFF;
      end else begin
        case (chState[c])
          pspc_pkg::CH_OFF: begin
            if (cmdOnReg && chanEn[c] && !shutdownMode && !swFault) begin
              chState[c] <= pspc_pkg::CH_INRUSH;
            end
          end
          pspc_pkg::CH_INRUSH: begin
            if (hostKill || startKill[c]) begin
              chState[c] <= pspc_pkg::CH_OFF;
            end else if (startDone[c]) begin
              chState[c] <= pspc_pkg::CH_ON;
            end
          end
          pspc_pkg::CH_ON: begin
            if (hostKill || onKill[c]) begin
              chState[c] <= pspc_pkg::CH_OFF;
            end
          end
          default: chState[c] <= pspc_pkg::CH_OFF;
        endcase
      end
    end
  end

  // ==========================================================================
  // Switch fault detection
  logic [pspc_pkg::CNT_W-1:0] swCnt;
  logic swDetect;
  assign swDetect = (swCnt >= pspc_pkg::CNT_W'(SWF_CYC - 1));
  always_ff @(posedge mclk) begin
    if (rst || cmdResetReg || shutdownMode || sSwAbn == 2'b00) begin
      swCnt <= '0;
    end else if (!swDetect) begin
      swCnt <= swCnt + 1'b1;
    end
  end

  // ==========================================================================
  // Sticky faults, write one to clear bits 7:0, set wins; switch fault clears only on reset command or shutdown
  logic [8:0] faultSet, faultClr;
  assign faultSet = {swDetect, discKill, ilimSet, pcutSet, startSet};
  assign faultClr = (wrFault && wStrbReg[0]) ? {1'b0, wDataReg[7:0]} : 9'h000;
  always_ff @(posedge mclk) begin
    if (rst || cmdResetReg) begin
      faultReg <= '0;
    end else if (shutdownMode) begin
      faultReg <= {1'b0, (faultReg[7:0] & ~faultClr[7:0]) | faultSet[7:0]};
    end else begin
      faultReg <= (faultReg & ~faultClr) | faultSet;
    end
  end

  // ==========================================================================
  // Analog-facing outputs
  for (genvar c = 0; c < 2; c++) begin : g_out
    always_ff @(posedge mclk) begin
      if (rst) begin
        gateEnable[c] <= 1'b0;
        inrushLimitHalf[c] <= 1'b0;
        currentLimitSel[2*c +: 2] <= 2'b00;
        foldbackStage[2*c +: 2] <= 2'b00;
        holdThresholdHigh[c] <= 1'b0;
      end else begin
        gateEnable[c] <= (chState[c] != pspc_pkg::CH_OFF) && !sSurge && !swFault;
        inrushLimitHalf[c] <= ss4p && (pdClass <= pspc_pkg::CLASS_HALF_MAX);
        currentLimitSel[2*c +: 2] <= ilimFromThr(chThr[c]);
        foldbackStage[2*c +: 2] <= sLow2[c] ? 2'b10 : (sLow1[c] ? 2'b01 : 2'b00);
        holdThresholdHigh[c] <= (classEvents >= pspc_pkg::EVENTS_HOLD_HIGH);
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      gatePulldownWeak <= 1'b0;
    end else begin
      gatePulldownWeak <= swFault;
    end
  end

endmodule : pspc_top

// File: logic/pspc_pkg.sv
/*
  Shared constants for the per-port power controller: register map,
  field positions, reset values, timing figures and their cycle counts.
  Assumes a 50 MHz controller clock.
*/
package pspc_pkg;

  // ==========================================================================
  // Clock and times
  localparam int CLK_MHZ = 50;
  localparam int T_START_US = 60000;
  localparam int T_DISC_US = 350000;
  localparam int T_SWF_US = 3800;
  localparam int T_LIM50_US = 50000;
  localparam int T_LIM15_US = 15000;
  localparam int T_LIM10_US = 10000;
  localparam int T_LIM6_US = 6000;
  localparam int START_CYC = T_START_US * CLK_MHZ;
  localparam int DIS_CYC = T_DISC_US * CLK_MHZ;
  localparam int SWF_CYC = T_SWF_US * CLK_MHZ;
  localparam int LIM50_CYC = T_LIM50_US * CLK_MHZ;
  localparam int LIM15_CYC = T_LIM15_US * CLK_MHZ;
  localparam int LIM10_CYC = T_LIM10_US * CLK_MHZ;
  localparam int LIM6_CYC = T_LIM6_US * CLK_MHZ;
  localparam int CNT_W = 25;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PORT_THR = 8'h04;
  localparam logic [7:0] ADDR_CH_THR = 8'h08;
  localparam logic [7:0] ADDR_TLIM = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FAULT = 8'h14;

  // ==========================================================================
  // Control fields
  localparam int CTRL_ON = 0;
  localparam int CTRL_OFF = 1;
  localparam int CTRL_RESET = 2;
  localparam int CTRL_SHUTDOWN = 3;
  localparam int CTRL_CHEN = 4;
  localparam int CTRL_DUAL = 6;
  localparam int CTRL_PCUT4P = 7;
  localparam int CTRL_ILIM4P = 8;
  localparam int CTRL_AUTO = 9;
  localparam int CTRL_DCEN = 10;
  localparam int CTRL_CLASS = 12;
  localparam int CTRL_EVENTS = 16;
  localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0C00;
  localparam logic [8:0] THR_RESET_VAL = 9'h100;
  localparam logic [3:0] TLIM_RESET_VAL = 4'h0;

  // ==========================================================================
  // Fault fields
  localparam int FLT_START = 0;
  localparam int FLT_PCUT = 2;
  localparam int FLT_ILIM = 4;
  localparam int FLT_DISC = 6;
  localparam int FLT_SWITCH = 8;

  // ==========================================================================
  // Decode limits
  localparam logic [8:0] THR_ILIM_LOW_MAX = 9'd31;
  localparam logic [8:0] THR_ILIM_MID_MAX = 9'd60;
  localparam logic [3:0] CLASS_HALF_MAX = 4'd4;
  localparam logic [2:0] EVENTS_HOLD_HIGH = 3'd4;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CH_OFF = 2'b00,
    CH_INRUSH = 2'b01,
    CH_ON = 2'b11
  } pspc_ch_e;

endpackage : pspc_pkg

// File: verification/pspc_pd_model.sv
/*
  Powered-device model behind the external switch and sense path.
  Assumes gateEnable from pspc_top and scenario controls from the bench.
*/
`timescale 1ns/1ps
module pspc_pd_model (
  // Clock
  input wire logic mclk,
  // Gate drive and scenario
  input wire logic [1:0] gateEnable,
  input wire logic pdPresent,
  input wire logic lightLoad,
  // Sense comparators
  output logic [1:0] overInrush,
  output logic [1:0] outputGood,
  output logic [1:0] belowHoldCurrent
);
  // ==========================================================================
  // Load response
  always_ff @(posedge mclk) begin
    overInrush <= 2'h0;
    outputGood <= pdPresent ? gateEnable : 2'h0;
    belowHoldCurrent <= (lightLoad || !pdPresent) ? 2'h3 : ~gateEnable;
  end
endmodule : pspc_pd_model

// File: verification/pspc_top_properties.sv
/*
  Port-level assertions for pspc_top.
  Bound to every pspc_top instance; sees its ports only.
*/
`timescale 1ns/1ps
module pspc_top_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Pins
  input wire logic supplySurge,
  input wire logic [1:0] voltLowStage2,
  input wire logic [1:0] gateEnable,
  input wire logic [1:0] inrushLimitHalf,
  input wire logic [3:0] currentLimitSel,
  input wire logic [3:0] foldbackStage,
  input wire logic gatePulldownWeak
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence wTaken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence rTaken; s_axi_arvalid && s_axi_arready; endsequence
  // ==========================================================================
  // Checks
  surge_gate_off_a: assert property (supplySurge [*8] |-> gateEnable == 2'h0)
    else $error("gate driven during surge");
  weak_gate_off_a: assert property (gatePulldownWeak [*2] |-> gateEnable == 2'h0)
    else $error("gate driven with weak pulldown");
  half_both_a: assert property (inrushLimitHalf != 2'h0 |-> inrushLimitHalf == 2'h3)
    else $error("half inrush on one channel only");
  limit_code_a: assert property (currentLimitSel[1:0] != 2'h3 && currentLimitSel[3:2] != 2'h3)
    else $error("unused current limit code");
  fold_deep_a: assert property (voltLowStage2[0] [*8] |-> foldbackStage[1:0] == 2'h2)
    else $error("no second foldback stage");
  write_answer_a: assert property (wTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  read_answer_a: assert property (rTaken |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
  reset_idle_a: assert property (disable iff (1'b0)
    rst |=> s_axi_awready && !s_axi_bvalid && gateEnable == 2'h0)
    else $error("outputs not idle after reset");
endmodule : pspc_top_checker

bind pspc_top pspc_top_checker u_pspc_top_checker (.mclk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .supplySurge, .voltLowStage2, .gateEnable,
  .inrushLimitHalf, .currentLimitSel, .foldbackStage, .gatePulldownWeak);

// File: verification/testbench.sv
/*
  Self-checking bench for pspc_top with a powered-device model.
  Assumes short timer parameters and an AXI4-Lite master in tasks.
*/
`timescale 1ns/1ps
module testbench;
  localparam int ST = 20;
  localparam int DT = 30;
  localparam int SW = 15;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, lastResp, overInrush, outputGood, belowHoldCurrent;
  logic [1:0] overCurrentLimit = 2'h0, switchAbnormal = 2'h0;
  logic [1:0] voltLowStage1 = 2'h0, voltLowStage2 = 2'h0;
  logic [1:0] gateEnable, inrushLimitHalf, holdThresholdHigh;
  logic supplySurge = 1'h0, pdPresent = 1'h1, lightLoad = 1'h0, gatePulldownWeak;
  logic [9:0] portPowerAvg = 10'h000;
  logic [8:0] chPowerAvg0 = 9'h000, chPowerAvg1 = 9'h000;
  logic [3:0] currentLimitSel, foldbackStage;
  int n_mismatch = 0;
  int compares = 0;

  always #10 mclk = ~mclk;

  pspc_top #(.START_CYC(ST), .DIS_CYC(DT), .SWF_CYC(SW), .LIM50_CYC(40), .LIM15_CYC(30),
    .LIM10_CYC(20), .LIM6_CYC(10)) u_pspc_top (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .overInrush, .overCurrentLimit,
    .belowHoldCurrent, .outputGood, .switchAbnormal, .voltLowStage1, .voltLowStage2,
    .supplySurge, .portPowerAvg, .chPowerAvg0, .chPowerAvg1, .gateEnable, .inrushLimitHalf,
    .currentLimitSel, .foldbackStage, .holdThresholdHigh, .gatePulldownWeak);
  pspc_pd_model u_pspc_pd_model (.mclk, .gateEnable, .pdPresent, .lightLoad, .overInrush,
    .outputGood, .belowHoldCurrent);

  // ==========================================================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    lastResp = s_axi_rresp;
    chk(nm, e, s_axi_rdata);
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  // ==========================================================================
  // Tests
  initial begin
    cyc(3);
    rst <= 1'h0;
    rd(pspc_pkg::ADDR_CTRL, pspc_pkg::CTRL_RESET_VAL, "ctrl");
    rd(8'h18, 32'h0, "unmapped");
    chk("rresp", pspc_pkg::AXI_SLVERR, lastResp);
    $display("TEST reset done");
    wr(pspc_pkg::ADDR_CTRL, 32'h0000_3DB1);
    rd(pspc_pkg::ADDR_STATUS, 32'h0000_0305, "inrush");
    chk("half", 2'h3, inrushLimitHalf);
    cyc(ST + 10);
    rd(pspc_pkg::ADDR_STATUS, 32'h0000_030F, "powered");
    supplySurge <= 1'h1;
    voltLowStage2 <= 2'h1;
    cyc(12);
    chk("surge", 2'h0, gateEnable);
    chk("fold", 4'h2, foldbackStage);
    supplySurge <= 1'h0;
    voltLowStage2 <= 2'h0;
    cyc(12);
    chk("recover", 2'h3, gateEnable);
    $display("TEST power done");
    wr(pspc_pkg::ADDR_CH_THR, 32'h0020_001F);
    cyc(3);
    chk("sel", 4'h4, currentLimitSel);
    wr(pspc_pkg::ADDR_CH_THR, 32'h003D_003C);
    cyc(3);
    chk("sel", 4'h9, currentLimitSel);
    chPowerAvg0 <= 9'h03D;
    cyc(6);
    rd(pspc_pkg::ADDR_FAULT, 32'h0000_000C, "pcut");
    rd(pspc_pkg::ADDR_STATUS, 32'h0, "pcut off");
    chPowerAvg0 <= 9'h000;
    wr(pspc_pkg::ADDR_FAULT, 32'h0000_00FF);
    rd(pspc_pkg::ADDR_FAULT, 32'h0, "w1c");
    $display("TEST police done");
    wr(pspc_pkg::ADDR_TLIM, 32'h0000_000F);
    rd(pspc_pkg::ADDR_TLIM, 32'h0000_000F, "tlim");
    wr(pspc_pkg::ADDR_CTRL, 32'h0000_3DB1);
    cyc(ST + 10);
    overCurrentLimit <= 2'h1;
    cyc(25);
    rd(pspc_pkg::ADDR_FAULT, 32'h0000_0030, "ilim");
    overCurrentLimit <= 2'h0;
    wr(pspc_pkg::ADDR_FAULT, 32'h0000_00FF);
    $display("TEST limit done");
    pdPresent <= 1'h0;
    wr(pspc_pkg::ADDR_CTRL, 32'h0000_3DB1);
    cyc(ST + 10);
    rd(pspc_pkg::ADDR_FAULT, 32'h0000_0003, "start");
    rd(pspc_pkg::ADDR_STATUS, 32'h0, "start off");
    pdPresent <= 1'h1;
    wr(pspc_pkg::ADDR_FAULT, 32'h0000_00FF);
    $display("TEST start done");
    wr(pspc_pkg::ADDR_CTRL, 32'h0004_31B1);
    cyc(ST + 10);
    chk("hold", 2'h3, holdThresholdHigh);
    lightLoad <= 1'h1;
    cyc(DT + 20);
    rd(pspc_pkg::ADDR_STATUS, 32'h0000_030F, "dc off");
    portPowerAvg <= 10'h101;
    rd(pspc_pkg::ADDR_FAULT, 32'h0000_000C, "port pcut");
    portPowerAvg <= 10'h000;
    wr(pspc_pkg::ADDR_CTRL, 32'h0004_3DB1);
    cyc(DT + ST + 20);
    rd(pspc_pkg::ADDR_FAULT, 32'h0000_00CC, "disc");
    rd(pspc_pkg::ADDR_STATUS, 32'h0, "disc off");
    lightLoad <= 1'h0;
    wr(pspc_pkg::ADDR_FAULT, 32'h0000_00FF);
    $display("TEST disconnect done");
    switchAbnormal <= 2'h1;
    cyc(SW + 10);
    rd(pspc_pkg::ADDR_FAULT, 32'h0000_0100, "switch");
    chk("weak", 1'h1, gatePulldownWeak);
    switchAbnormal <= 2'h0;
    wr(pspc_pkg::ADDR_CTRL, 32'h0004_3DB4);
    cyc(4);
    rd(pspc_pkg::ADDR_FAULT, 32'h0, "swf clear");
    $display("TEST switch done");
    final_report;
  end

  initial begin
    cyc(20000);
    n_mismatch++;
    $display("MISMATCH watchdog expected finish seen timeout");
    final_report;
  end
endmodule : testbench
